// >>> include/tmr_route_defines.svh
// register offsets, field positions, reset values and codes for the timer routing block
`ifndef TMR_ROUTE_DEFINES_SVH
`define TMR_ROUTE_DEFINES_SVH
`define AB_SEL_OFS 10'h182
`define CD_SEL_OFS 10'h183
`define MODE_OFS 10'h184
`define CTRL_OFS 10'h185
`define IRQ_STAT_OFS 10'h186
`define IRQ_CLR_OFS 10'h187
`define IRQ_EN_OFS 10'h188
`define CNT_OFS 10'h189
`define VAL_A_OFS 10'h18a
`define VAL_B_OFS 10'h18b
`define VAL_C_OFS 10'h18c
`define VAL_D_OFS 10'h18d
`define SEL_RESET 8'h00
`define AB_SEL_MASK 8'hf7
`define CD_SEL_MASK 8'h77
`define CKS_EXT 3'h5
`define CKS_FAST 3'h6
`define CKS_FAST_DIV 3'h7
`endif

// >>> include/tmr_route_pkg.sv
// types for the timer routing, count source and buffer block
package tmr_route_pkg;
	typedef enum logic [3:0] {
		MODE_CAPTURE = 4'b0001,
		MODE_COMPARE = 4'b0010,
		MODE_PWM = 4'b0100,
		MODE_SINGLE_SHOT_PWM_MODE = 4'b1000
	} tmr_mode_t;
	typedef struct packed {
		logic [9:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic cap_a;
		logic cap_b;
		logic cap_c;
		logic cap_d;
		logic trig;
	} chan_evt_t;
endpackage

// >>> hdl/tmr_route.sv
// pin routing, count source selection and buffer operation of a 16-bit capture/compare timer
//
// Contract
// - chan A/trigger route bits 2:0; 001 p1.1,010 p0.0,011 p0.1,100 p0.2,110 p3.1.
// - chan B route bits 7:4; 0001 port1 bit2, 1001 port4 bit5, else none.
// - chan C route bits 2:0 of second register; 001 p1.3, 010 p3.4.
// - chan D route bits 6:4 of second register; 001 p1.0, 010 p3.5.
// - unassigned select bits read zero; software writes zero.
// - counter source from clock select: system clock divided by 1,2,4,8,32.
// - select 110 picks fast oscillator, 111 divided fast oscillator, only while on.
// - select 101 counts rising edges of external clock pin.
// - buffer enables make C buffer for A and D buffer for B.
// - capture with buffering moves old channel value into buffer, then loads count.
// - compare or pwm with buffering copies buffer into channel on match.
// - single_shot_pwm_mode with buffering copies D into B on A match or trigger event.
// - compare-side buffer sets its match flag on counter match.
// - capture-side buffer sets its flag on selected edge at C or D pin.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "tmr_route_defines.svh"
module tmr_route import tmr_route_pkg::*; #(
	parameter int CW = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [9:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic [1:0] p0_in,
	input wire logic [3:0] p1_in,
	input wire logic [1:0] p3_in,
	input wire logic p3_5_in,
	input wire logic p4_5_in,
	input wire logic p0_2_in,
	input wire logic ext_clock_pin,
	input wire logic fast_osc_clock,
	input wire logic fast_osc_divided_clock,
	input wire logic fast_osc_on_bit,
	output logic irq,
	output logic count_tick
);
	// ==========================================
	// registers
	reg_req_t req;
	logic [7:0] ab_sel_q, cd_sel_q;
	logic [7:0] mode_q;
	logic [7:0] ctrl_q;
	logic [1:0] stat_q, en_q;
	logic [CW-1:0] cnt_q, va_q, vb_q, vc_q, vd_q;
	logic [15:0] rdata_q;
	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	// mode fields: bit0 buffer_c_enable, bit1 buffer_d_enable, bits7:4 one-hot mode
	logic buffer_c_enable, buffer_d_enable;
	tmr_mode_t mode;
	assign buffer_c_enable = mode_q[0];
	assign buffer_d_enable = mode_q[1];
	assign mode = tmr_mode_t'(mode_q[7:4]);
	// ctrl: bits 2:0 clock_select_field, bit 7 run
	logic [2:0] clock_select_field;
	logic run;
	assign clock_select_field = ctrl_q[2:0];
	assign run = ctrl_q[7];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ab_sel_q <= `SEL_RESET;
			cd_sel_q <= `SEL_RESET;
			mode_q <= 8'h10;
			ctrl_q <= 8'h00;
			en_q <= 2'h0;
		end else if (req.wr) begin
			unique case (req.addr)
				`AB_SEL_OFS: ab_sel_q <= req.wdata[7:0] & `AB_SEL_MASK;
				`CD_SEL_OFS: cd_sel_q <= req.wdata[7:0] & `CD_SEL_MASK;
				`MODE_OFS: mode_q <= req.wdata[7:0];
				`CTRL_OFS: ctrl_q <= req.wdata[7:0];
				`IRQ_EN_OFS: en_q <= req.wdata[1:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// pin routing
	logic chan_a_pin, chan_b_pin, chan_c_pin, chan_d_pin, trigger_pin;
	logic [2:0] chan_a_route_field, chan_c_route_field, chan_d_route_field;
	logic [3:0] chan_b_route_field;
	assign chan_a_route_field = ab_sel_q[2:0];
	assign chan_b_route_field = ab_sel_q[7:4];
	assign chan_c_route_field = cd_sel_q[2:0];
	assign chan_d_route_field = cd_sel_q[6:4];
	always_comb begin
		// reserved codes leave the channel low, disconnected
		unique case (chan_a_route_field)
			3'h1: chan_a_pin = p1_in[1];
			3'h2: chan_a_pin = p0_in[0];
			3'h3: chan_a_pin = p0_in[1];
			3'h4: chan_a_pin = p0_2_in;
			3'h6: chan_a_pin = p3_in[1];
			default: chan_a_pin = 1'b0;
		endcase
		unique case (chan_b_route_field)
			4'h1: chan_b_pin = p1_in[2];
			4'h9: chan_b_pin = p4_5_in;
			default: chan_b_pin = 1'b0;
		endcase
		unique case (chan_c_route_field)
			3'h1: chan_c_pin = p1_in[3];
			3'h2: chan_c_pin = p3_in[0];
			default: chan_c_pin = 1'b0;
		endcase
		unique case (chan_d_route_field)
			3'h1: chan_d_pin = p1_in[0];
			3'h2: chan_d_pin = p3_5_in;
			default: chan_d_pin = 1'b0;
		endcase
	end
	assign trigger_pin = chan_a_pin;

	// ==========================================
	// count source
	logic [4:0] pre_q;
	logic ext_q, fo_q, fd_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_q <= 5'h00;
			ext_q <= 1'b0;
			fo_q <= 1'b0;
			fd_q <= 1'b0;
		end else begin
			pre_q <= pre_q + 5'h01;
			ext_q <= ext_clock_pin;
			fo_q <= fast_osc_clock;
			fd_q <= fast_osc_divided_clock;
		end
	end
	// pins taken as synchronous; sampling limits external rate, hence three-cycle pulses
	always_comb begin
		unique case (clock_select_field)
			3'h0: count_tick = 1'b1;
			3'h1: count_tick = pre_q[0:0] == 1'b1;
			3'h2: count_tick = pre_q[1:0] == 2'h3;
			3'h3: count_tick = pre_q[2:0] == 3'h7;
			3'h4: count_tick = pre_q == 5'h1f;
			`CKS_EXT: count_tick = ext_clock_pin & ~ext_q;
			`CKS_FAST: count_tick = fast_osc_on_bit & fast_osc_clock & ~fo_q;
			`CKS_FAST_DIV: count_tick = fast_osc_on_bit & fast_osc_divided_clock & ~fd_q;
		endcase
	end

	// ==========================================
	// edge detection and matches
	logic [3:0] pin_q;
	chan_evt_t ev;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_q <= 4'h0;
		end else begin
			pin_q <= {chan_d_pin, chan_c_pin, chan_b_pin, chan_a_pin};
		end
	end
	// rising edge selected as the capture edge
	assign ev.cap_a = chan_a_pin & ~pin_q[0];
	assign ev.cap_b = chan_b_pin & ~pin_q[1];
	assign ev.cap_c = chan_c_pin & ~pin_q[2];
	assign ev.cap_d = chan_d_pin & ~pin_q[3];
	assign ev.trig = ev.cap_a;
	logic cmp, m_a, m_b, m_c, m_d;
	assign cmp = mode != MODE_CAPTURE;
	assign m_a = run && cnt_q == va_q;
	assign m_b = run && cnt_q == vb_q;
	assign m_c = run && cnt_q == vc_q;
	assign m_d = run && cnt_q == vd_q;

	// ==========================================
	// counter and channel values
	function automatic logic [CW-1:0] wr16(input logic [15:0] d);
		wr16 = d[CW-1:0];
	endfunction
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (req.wr && req.addr == `CNT_OFS) begin
			cnt_q <= wr16(req.wdata);
		end else if (run && count_tick) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			va_q <= '1;
			vc_q <= '1;
		end else if (req.wr && req.addr == `VAL_A_OFS) begin
			va_q <= wr16(req.wdata);
		end else if (req.wr && req.addr == `VAL_C_OFS) begin
			vc_q <= wr16(req.wdata);
		end else if (!cmp && run && ev.cap_a) begin
			if (buffer_c_enable) vc_q <= va_q;
			va_q <= cnt_q;
		end else if (cmp && buffer_c_enable && m_a && mode != MODE_SINGLE_SHOT_PWM_MODE) begin
			va_q <= vc_q;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vb_q <= '1;
			vd_q <= '1;
		end else if (req.wr && req.addr == `VAL_B_OFS) begin
			vb_q <= wr16(req.wdata);
		end else if (req.wr && req.addr == `VAL_D_OFS) begin
			vd_q <= wr16(req.wdata);
		end else if (!cmp && run && ev.cap_b) begin
			if (buffer_d_enable) vd_q <= vb_q;
			vb_q <= cnt_q;
		end else if (buffer_d_enable && mode == MODE_SINGLE_SHOT_PWM_MODE && (m_a || ev.trig)) begin
			vb_q <= vd_q;
		end else if (cmp && buffer_d_enable && m_b && mode != MODE_SINGLE_SHOT_PWM_MODE) begin
			vb_q <= vd_q;
		end
	end

	// ==========================================
	// status flags and interrupt
	logic [1:0] set_f, clr_f;
	assign set_f[0] = buffer_c_enable && (cmp ? m_c : ev.cap_c);
	assign set_f[1] = buffer_d_enable && (cmp ? m_d : ev.cap_d);
	assign clr_f = (req.wr && req.addr == `IRQ_CLR_OFS) ? req.wdata[1:0] : 2'h0;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_q <= 2'h0;
		end else begin
			// set wins over a clear in the same cycle
			stat_q <= (stat_q & ~clr_f) | set_f;
		end
	end
	assign irq = |(stat_q & en_q);

	// ==========================================
	// read port
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 16'h0000;
		end else if (req.rd) begin
			unique case (req.addr)
				`AB_SEL_OFS: rdata_q <= {8'h00, ab_sel_q};
				`CD_SEL_OFS: rdata_q <= {8'h00, cd_sel_q};
				`MODE_OFS: rdata_q <= {8'h00, mode_q};
				`CTRL_OFS: rdata_q <= {8'h00, ctrl_q};
				`IRQ_STAT_OFS: rdata_q <= {14'h0, stat_q};
				`IRQ_EN_OFS: rdata_q <= {14'h0, en_q};
				`CNT_OFS: rdata_q <= 16'(cnt_q);
				`VAL_A_OFS: rdata_q <= 16'(va_q);
				`VAL_B_OFS: rdata_q <= 16'(vb_q);
				`VAL_C_OFS: rdata_q <= 16'(vc_q);
				`VAL_D_OFS: rdata_q <= 16'(vd_q);
				default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end
	assign rdata = rdata_q;

	// ==========================================
	// assertions
	property p_sel_zero;
		@(posedge clk) disable iff (!rst_b)
			(ab_sel_q[3] == 1'b0) && (cd_sel_q[7] == 1'b0) && (cd_sel_q[3] == 1'b0);
	endproperty
	a_sel_zero: assert property (p_sel_zero) else $error("select reserved bit set");
	property p_route_b;
		@(posedge clk) disable iff (!rst_b)
			(chan_b_route_field != 4'h1 && chan_b_route_field != 4'h9) |-> !chan_b_pin;
	endproperty
	a_route_b: assert property (p_route_b) else $error("chan b routed on reserved code");
	property p_route_b9;
		@(posedge clk) disable iff (!rst_b)
			(chan_b_route_field == 4'h9) |-> chan_b_pin == p4_5_in;
	endproperty
	a_route_b9: assert property (p_route_b9) else $error("chan b port4 route wrong");
	property p_route_a;
		@(posedge clk) disable iff (!rst_b)
			(chan_a_route_field == 3'h6) |-> chan_a_pin == p3_in[1];
	endproperty
	a_route_a: assert property (p_route_a) else $error("chan a route wrong");
	// reserved codes must not leak any port level into the capture logic
	property p_route_a_off;
		@(posedge clk) disable iff (!rst_b)
			(chan_a_route_field == 3'h5 || chan_a_route_field == 3'h7) |-> !chan_a_pin;
	endproperty
	a_route_a_off: assert property (p_route_a_off) else $error("chan a reserved leak");
	property p_route_c;
		@(posedge clk) disable iff (!rst_b)
			(chan_c_route_field == 3'h2) |-> chan_c_pin == p3_in[0];
	endproperty
	a_route_c: assert property (p_route_c) else $error("chan c route wrong");
	property p_route_d;
		@(posedge clk) disable iff (!rst_b)
			(chan_d_route_field == 3'h1) |-> chan_d_pin == p1_in[0];
	endproperty
	a_route_d: assert property (p_route_d) else $error("chan d route wrong");
	property p_cap_buf;
		@(posedge clk) disable iff (!rst_b)
			(!cmp && run && buffer_c_enable && ev.cap_a && !req.wr)
			|=> vc_q == $past(va_q) && va_q == $past(cnt_q);
	endproperty
	a_cap_buf: assert property (p_cap_buf) else $error("capture buffer move wrong");
	property p_cap_buf_b;
		@(posedge clk) disable iff (!rst_b)
			(!cmp && run && buffer_d_enable && ev.cap_b && !req.wr)
			|=> vd_q == $past(vb_q) && vb_q == $past(cnt_q);
	endproperty
	a_cap_buf_b: assert property (p_cap_buf_b) else $error("chan b capture move wrong");
	property p_cmp_buf;
		@(posedge clk) disable iff (!rst_b)
			(mode == MODE_COMPARE && buffer_c_enable && m_a && !req.wr && !(ev.cap_a && !cmp))
			|=> va_q == $past(vc_q);
	endproperty
	a_cmp_buf: assert property (p_cmp_buf) else $error("compare buffer copy missing");
	property p_single_shot_pwm_mode;
		@(posedge clk) disable iff (!rst_b)
			(mode == MODE_SINGLE_SHOT_PWM_MODE && buffer_d_enable && ev.trig && !req.wr) |=> vb_q == $past(vd_q);
	endproperty
	a_single_shot_pwm_mode: assert property (p_single_shot_pwm_mode) else $error("single_shot_pwm_mode trigger copy missing");
	property p_single_shot_pwm_mode_match;
		@(posedge clk) disable iff (!rst_b)
			(mode == MODE_SINGLE_SHOT_PWM_MODE && buffer_d_enable && m_a && !req.wr) |=> vb_q == $past(vd_q);
	endproperty
	a_single_shot_pwm_mode_match: assert property (p_single_shot_pwm_mode_match) else $error("single_shot_pwm_mode match copy missing");
	property p_flag;
		@(posedge clk) disable iff (!rst_b)
			set_f[1] |=> stat_q[1];
	endproperty
	a_flag: assert property (p_flag) else $error("chan d flag not set");
	property p_flag_c;
		@(posedge clk) disable iff (!rst_b)
			(cmp && buffer_c_enable && m_c) |=> stat_q[0];
	endproperty
	a_flag_c: assert property (p_flag_c) else $error("chan c match flag not set");
	property p_flag_cap;
		@(posedge clk) disable iff (!rst_b)
			(!cmp && buffer_c_enable && ev.cap_c) |=> stat_q[0];
	endproperty
	a_flag_cap: assert property (p_flag_cap) else $error("chan c edge flag not set");
	// a select change may start a faster source, so only ticks under /32 count
	property p_div32;
		@(posedge clk) disable iff (!rst_b)
			(clock_select_field == 3'h4 && count_tick)
			|=> (clock_select_field != 3'h4 || !count_tick) [*8];
	endproperty
	a_div32: assert property (p_div32) else $error("div32 tick too early");
	property p_cnt_hold;
		@(posedge clk) disable iff (!rst_b)
			(!run && !(req.wr && req.addr == `CNT_OFS)) |=> $stable(cnt_q);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved while stopped");
	property p_ext_edge;
		@(posedge clk) disable iff (!rst_b)
			(clock_select_field == `CKS_EXT && count_tick && !req.wr) |=> !count_tick;
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("external tick not an edge");
	// oscillator off means no tick even if the source line toggles
	property p_fast_gate;
		@(posedge clk) disable iff (!rst_b)
			(clock_select_field[2:1] == 2'h3 && !fast_osc_on_bit) |-> !count_tick;
	endproperty
	a_fast_gate: assert property (p_fast_gate) else $error("fast source ticks while off");
	c_cap: cover property (@(posedge clk) disable iff (!rst_b)
		!cmp && ev.cap_a && buffer_c_enable);
	c_single_shot_pwm_mode: cover property (@(posedge clk) disable iff (!rst_b) mode == MODE_SINGLE_SHOT_PWM_MODE && ev.trig);
	c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq);
	c_ext: cover property (@(posedge clk) disable iff (!rst_b)
		clock_select_field == `CKS_EXT && count_tick);
endmodule

// >>> tb/pin_model.sv
// far-side model: port pins, external clock pin and oscillator outputs
`timescale 1ns/1ps
module pin_model (
	input wire logic clk,
	output logic [10:0] pins,
	output logic ext_clock_pin,
	output logic fast_osc_clock,
	output logic fast_osc_divided_clock
);
	logic [3:0] div_q = 4'h0;
	initial begin
		pins = 11'h000;
	end
	always @(posedge clk) begin
		div_q <= div_q + 4'h1;
	end
	// external and fast clocks high and low four cycles each, divided clock eight each, above the three-cycle floor
	assign ext_clock_pin = div_q[2];
	assign fast_osc_clock = div_q[2];
	assign fast_osc_divided_clock = div_q[3];
	// held four cycles so any input sampler sees a clean edge
	task automatic pulse(input logic [10:0] m);
		@(posedge clk);
		pins <= m;
		repeat (4) @(posedge clk);
		pins <= 11'h000;
		repeat (4) @(posedge clk);
	endtask
endmodule

// >>> tb/tmr_route_bench.sv
// self-checking bench for the timer routing, count source and buffer block
`timescale 1ns/1ps
`include "tmr_route_defines.svh"
module tmr_route_bench import tmr_route_pkg::*;;
	typedef struct packed {
		logic [7:0] ab;
		logic [7:0] cd;
		logic [10:0] pm;
		logic [3:0] ex;
	} row_t;
	row_t rows[16] = '{'{8'h01, 8'h00, 11'h010, 4'h8}, '{8'h01, 8'h00, 11'h7ef, 4'h0},
		'{8'h02, 8'h00, 11'h001, 4'h8}, '{8'h03, 8'h00, 11'h002, 4'h8},
		'{8'h04, 8'h00, 11'h004, 4'h8}, '{8'h06, 8'h00, 11'h080, 4'h8},
		'{8'h05, 8'h00, 11'h7ff, 4'h0}, '{8'h0f, 8'h00, 11'h7ff, 4'h0},
		'{8'h10, 8'h00, 11'h020, 4'h4}, '{8'h90, 8'h00, 11'h400, 4'h4},
		'{8'h20, 8'h00, 11'h7ff, 4'h0}, '{8'h00, 8'h01, 11'h040, 4'h2},
		'{8'h00, 8'h02, 11'h100, 4'h2}, '{8'h00, 8'h10, 11'h008, 4'h1},
		'{8'h00, 8'h20, 11'h200, 4'h1}, '{8'h00, 8'hbb, 11'h7ff, 4'h0}};
	logic [25:0] rv[12] = '{26'h1820000, 26'h1830000, 26'h1840010, 26'h1850000,
		26'h1860000, 26'h1880000, 26'h1890000, 26'h18affff, 26'h18bffff, 26'h18cffff,
		26'h18dffff, 26'h1ff0000};
	logic [11:0] ck[9] = '{12'h140, 12'h320, 12'h510, 12'h708, 12'h902, 12'hb08, 12'hd08,
		12'hf04, 12'hc00};
	logic [15:0] md[2] = '{16'h0021, 16'h0041};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [9:0] addr = 10'h000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fast_osc_on_bit = 1'b0;
	logic [15:0] rdata, v, a1;
	logic irq, count_tick, ext_clk, fo, fod;
	logic [10:0] pins;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	always #2 clk = ~clk;
	pin_model u_pin_model (.clk(clk), .pins(pins), .ext_clock_pin(ext_clk),
		.fast_osc_clock(fo), .fast_osc_divided_clock(fod));
	tmr_route u_tmr_route (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .p0_in(pins[1:0]), .p1_in(pins[6:3]),
		.p3_in({pins[7], pins[8]}), .p3_5_in(pins[9]), .p4_5_in(pins[10]), .p0_2_in(pins[2]),
		.ext_clock_pin(ext_clk), .fast_osc_clock(fo), .fast_osc_divided_clock(fod),
		.fast_osc_on_bit(fast_osc_on_bit), .irq(irq), .count_tick(count_tick));
	// =====================================
	// tasks
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [9:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk_reg(input logic [9:0] a, input logic [15:0] e);
		logic [15:0] r;
		rd_reg(a, r);
		check(r, e);
	endtask
	// reset clears both select registers to their reset value
	task automatic do_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	// =====================================
	// sequence
	initial begin
		do_reset();
		check({15'h0, irq}, 16'h0000);
		foreach (rv[i]) chk_reg(rv[i][25:16], rv[i][15:0]);
		$display("reset values done");
		foreach (rows[i]) begin
			do_reset();
			wr_reg(`AB_SEL_OFS, {8'h00, rows[i].ab});
			wr_reg(`CD_SEL_OFS, {8'h00, rows[i].cd});
			wr_reg(`MODE_OFS, 16'h0013);
			wr_reg(`CTRL_OFS, 16'h0080);
			u_pin_model.pulse(rows[i].pm);
			chk_reg(`AB_SEL_OFS, {8'h00, rows[i].ab & 8'hf7});
			chk_reg(`CD_SEL_OFS, {8'h00, rows[i].cd & 8'h77});
			rd_reg(`VAL_A_OFS, v);
			check({15'h0, v !== 16'hffff}, {15'h0, rows[i].ex[3]});
			rd_reg(`VAL_B_OFS, v);
			check({15'h0, v !== 16'hffff}, {15'h0, rows[i].ex[2]});
			chk_reg(`IRQ_STAT_OFS, {14'h0, rows[i].ex[0], rows[i].ex[1]});
		end
		$display("routing table done");
		do_reset();
		wr_reg(`AB_SEL_OFS, 16'h0002);
		wr_reg(`MODE_OFS, 16'h0011);
		wr_reg(`CTRL_OFS, 16'h0080);
		u_pin_model.pulse(11'h001);
		rd_reg(`VAL_A_OFS, a1);
		chk_reg(`VAL_C_OFS, 16'hffff);
		u_pin_model.pulse(11'h001);
		chk_reg(`VAL_C_OFS, a1);
		$display("buffered capture done");
		foreach (md[i]) begin
			do_reset();
			wr_reg(`MODE_OFS, md[i]);
			wr_reg(`VAL_A_OFS, 16'h0005);
			wr_reg(`VAL_C_OFS, 16'h0030);
			wr_reg(`CTRL_OFS, 16'h0080);
			repeat (100) @(posedge clk);
			chk_reg(`VAL_A_OFS, 16'h0030);
			chk_reg(`IRQ_STAT_OFS, 16'h0001);
			check({15'h0, irq}, 16'h0000);
			wr_reg(`IRQ_EN_OFS, 16'h0001);
			check({15'h0, irq}, 16'h0001);
			wr_reg(`IRQ_CLR_OFS, 16'h0001);
			check({15'h0, irq}, 16'h0000);
			chk_reg(`IRQ_STAT_OFS, 16'h0000);
		end
		$display("buffered compare done");
		do_reset();
		wr_reg(`AB_SEL_OFS, 16'h0002);
		wr_reg(`MODE_OFS, 16'h0082);
		wr_reg(`VAL_D_OFS, 16'h1234);
		wr_reg(`VAL_A_OFS, 16'h0040);
		wr_reg(`CTRL_OFS, 16'h0080);
		repeat (100) @(posedge clk);
		chk_reg(`VAL_B_OFS, 16'h1234);
		wr_reg(`VAL_D_OFS, 16'h5555);
		u_pin_model.pulse(11'h001);
		chk_reg(`VAL_B_OFS, 16'h5555);
		$display("single shot buffer done");
		do_reset();
		foreach (ck[i]) begin
			// oscillator on bit set from the table row before its select is written
			@(posedge clk);
			fast_osc_on_bit <= ck[i][8];
			wr_reg(`CTRL_OFS, {8'h00, 5'h10, ck[i][11:9]});
			repeat (8) @(posedge clk);
			n = 0;
			repeat (64) begin
				@(negedge clk);
				if (count_tick === 1'b1) n++;
			end
			check(16'(n), {8'h00, ck[i][7:0]});
		end
		$display("count source done");
		give_verdict();
	end
endmodule
